/* src/ext_exec_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE_01) register sign extend copies bit 7 upward
// (RULE_02) address-word memory extend clears bits 31:20
// (RULE_03) word memory extend fills bits 15:8
// (RULE_04) extend flags: N, Z, C=!Z, V clear
// (RULE_05) mode bits of status never change
// (RULE_06) test adds all-ones plus one, no write
// (RULE_07) test flags: N, Z, C set, V clear
// (RULE_08) xor writes source xor destination
// (RULE_09) xor flags: C=!Z, V both negative
// (RULE_10) word register result clears bits 19:16; only the xor clears them, the sign extend fills them from bit 7
// (RULE_11) address class only register or immediate
// (RULE_12) address add overwrites destination register
// (RULE_13) address add flags from 20-bit sum
// (RULE_14) branch loads PC from 20-bit target
// (RULE_15) target low at X, high at X+2
// (RULE_16) auto-increment adds four to pointer
// (RULE_17) indexed target uses signed 16-bit index
// (RULE_18) call pushes PC high, low, then jumps
// (RULE_19) call uses exactly two stack words
// (RULE_20) jumps keep N, Z, C, V
// (RULE_21) N from bit 19, 15 or 7
// (RULE_22) byte register result clears bits 19:8
module ext_exec_unit (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  input  wire logic                  cmdValid,
  input  wire ext_exec_pkg::op_t     cmdOp,
  input  wire ext_exec_pkg::width_t  cmdWidth,
  input  wire ext_exec_pkg::mode_t   cmdMode,
  input  wire logic                  cmdSrcImm,
  input  wire logic [3:0]            cmdSrcReg,
  input  wire logic [3:0]            cmdDstReg,
  input  wire logic [19:0]           cmdImm,
  input  wire logic [19:0]           cmdAbs,
  input  wire logic [15:0]           cmdIndex,
  output logic                       cmdReady,
  output logic                       cmdDone,
  output logic                       cmdError,
  output logic                       memReq,
  output logic                       memWe,
  output logic [19:0]                memAddr,
  output logic [15:0]                memWdata,
  input  wire logic [15:0]           memRdata,
  input  wire logic                  memAck,
  input  wire logic [3:0]            peekIdx,
  output logic [19:0]                peekData
);
  import ext_exec_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  state_t      state_reg;        // sequencer
  state_t      state_next;
  logic [19:0] regFile [16];     // R0 = PC, R1 = SP, R2 = status
  op_t         op_reg;           // latched command
  width_t      width_reg;
  mode_t       mode_reg;
  logic [3:0]  dstIdx_reg;       // destination register
  logic [3:0]  ptrIdx_reg;       // register used by the operand mode
  logic        twoWords_reg;     // operand spans two memory words
  logic [19:0] opAddr_reg;       // effective address of the memory operand
  logic [19:0] srcVal_reg;       // source value taken at accept
  logic [19:0] tgt_reg;          // evaluated jump target
  logic [15:0] loData_reg;       // word read from X
  logic [15:0] hiData_reg;       // word read from X+2
  logic        memReq_reg;
  logic        memWe_reg;
  logic [19:0] memAddr_reg;
  logic [15:0] memWdata_reg;
  logic        cmdDone_reg;
  logic        cmdError_reg;
  logic [19:0] peekData_reg;

  // architectural registers seen by the decode
  wire [19:0] pcVal = regFile[PC_IDX];
  wire [19:0] spVal = regFile[SP_IDX];
  wire [19:0] srVal = regFile[SR_IDX];

  // command decode, valid in idle
  wire        cmdJump  = (cmdOp == ADDR_BRANCH) || (cmdOp == ADDR_CALL);
  wire        cmdMem   = (cmdMode != MD_REG) && (cmdMode != MD_IMM);
  wire [3:0]  ptrSel   = cmdJump ? cmdSrcReg : cmdDstReg;
  wire [19:0] ptrVal   = regFile[ptrSel];
  wire [19:0] index20  = {{4{cmdIndex[15]}}, cmdIndex};                 // [RULE_17]
  // effective address for the memory modes [RULE_14] [RULE_17]
  wire [19:0] eaNow    = (cmdMode == MD_ABS) ? cmdAbs :
                         (cmdMode == MD_SYM) ? pcVal + index20 :
                         (cmdMode == MD_IDX) ? ptrVal + index20 : ptrVal;
  // the add is register or immediate only, so it never reads memory [RULE_11]
  wire        badAdd   = (cmdOp == ADDR_ADD) && cmdMem;
  wire        badData  = !cmdJump && (cmdOp != ADDR_ADD)
                         && ((cmdMode == MD_IMM) || (cmdMode == MD_AINC));
  wire        badExt   = (cmdOp == EXT_SIGN_EXTEND) && (cmdWidth == WD_BYTE);
  wire        cmdBad   = badAdd || badData || badExt;
  wire        idleNow  = (state_reg == ST_IDLE);
  wire        accept   = clkEn && idleNow && cmdValid;
  wire        take     = accept && !cmdBad;
  wire        srcIsImm = (cmdMode == MD_IMM) || ((cmdOp == EXT_EXCLUSIVE_OR) && cmdSrcImm);
  wire [19:0] srcNow   = srcIsImm ? cmdImm : regFile[cmdSrcReg];
  wire [19:0] tgtNow   = (cmdMode == MD_IMM) ? cmdImm : ptrVal;

  // execute-side decode
  wire        jumpReg  = (op_reg == ADDR_BRANCH) || (op_reg == ADDR_CALL);
  wire        dataOp   = !jumpReg;
  wire        memMode  = (mode_reg != MD_REG) && (mode_reg != MD_IMM);
  wire        writesOp = (op_reg == EXT_SIGN_EXTEND) || (op_reg == EXT_EXCLUSIVE_OR);
  wire        byteLane = opAddr_reg[0];
  wire        ackNow   = memAck && memReq_reg;
  wire        execNow  = clkEn && (state_reg == ST_EXEC);
  wire        pushDone = clkEn && (state_reg == ST_PUSHLO) && ackNow;
  wire [7:0]  memByte  = byteLane ? loData_reg[15:8] : loData_reg[7:0];
  wire [19:0] memOperand = (width_reg == WD_ADDR) ? {hiData_reg[3:0], loData_reg} :
                           (width_reg == WD_WORD) ? {4'h0, loData_reg} :
                           {12'h000, memByte};
  wire [19:0] dstOperand = memMode ? memOperand : regFile[dstIdx_reg];
  wire [19:0] ptrNow     = regFile[ptrIdx_reg];

  logic [19:0] aluResult;
  logic        aluN;
  logic        aluZ;
  logic        aluC;
  logic        aluV;

  // shared datapath for the four data operations
  ext_alu alu (
    .aluOp    (op_reg),
    .aluWidth (width_reg),
    .srcVal   (srcVal_reg),
    .dstVal   (dstOperand),
    .result   (aluResult),
    .flagN    (aluN),
    .flagZ    (aluZ),
    .flagC    (aluC),
    .flagV    (aluV)
  );

  // status with the four flags replaced, mode bits carried over [RULE_05]
  wire [19:0] flagBits = ({19'h00000, aluC} << C_POS) | ({19'h00000, aluZ} << Z_POS)
                       | ({19'h00000, aluN} << N_POS) | ({19'h00000, aluV} << V_POS);
  wire [19:0] srFlagged = (srVal & ~SR_FLAG_MASK) | flagBits;

  // memory write-back words; a byte merges into its lane of the word read
  wire [15:0] byteMerge = byteLane ? {aluResult[7:0], loData_reg[7:0]}
                                   : {loData_reg[15:8], aluResult[7:0]};
  wire [15:0] wbLoNow   = (width_reg == WD_BYTE) ? byteMerge : aluResult[15:0];  // [RULE_03]
  wire [15:0] wbHiNow   = {12'h000, aluResult[19:16]};                         // [RULE_02]

  // write port A: data result, pointer step or stack pointer
  wire        wrEnA = (execNow && !memMode && dataOp && (op_reg != EXT_TEST_ZERO))
                    || (execNow && jumpReg && (mode_reg == MD_AINC)) || pushDone;
  wire [3:0]  wrIdxA = pushDone ? SP_IDX : (jumpReg ? ptrIdx_reg : dstIdx_reg);
  // two stack words go in one step of the pointer [RULE_18] [RULE_19]
  wire [19:0] rawA  = pushDone ? spVal - PUSH_PAIR :
                      jumpReg  ? ptrNow + AINC_STEP :                  // [RULE_16]
                      aluResult;                                       // [RULE_12]
  wire [19:0] wrDataA = (wrIdxA == SR_IDX) ? ((rawA & ~SR_MODE_MASK) | (srVal & SR_MODE_MASK))
                                           : rawA;                     // [RULE_05]
  // write port B: status flags, or PC on a jump; the call loads PC last
  wire        wrEnB   = (execNow && (dataOp || (op_reg == ADDR_BRANCH))) || pushDone;
  wire [3:0]  wrIdxB  = (execNow && dataOp) ? SR_IDX : PC_IDX;
  wire [19:0] wrDataB = (execNow && dataOp) ? srFlagged : tgt_reg;     // [RULE_14] [RULE_20]

  // next state of the sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (take) state_next = cmdMem ? ST_RDLO : ST_EXEC;
      ST_RDLO:   if (ackNow) state_next = twoWords_reg ? ST_RDHI : ST_EXEC;
      ST_RDHI:   if (ackNow) state_next = ST_EXEC;
      ST_EXEC:   state_next = (op_reg == ADDR_CALL) ? ST_PUSHHI :
                              (memMode && writesOp) ? ST_WRLO : ST_IDLE; // [RULE_06]
      ST_WRLO:   if (ackNow) state_next = (width_reg == WD_ADDR) ? ST_WRHI : ST_IDLE;
      ST_WRHI:   if (ackNow) state_next = ST_IDLE;
      ST_PUSHHI: if (ackNow) state_next = ST_PUSHLO;
      ST_PUSHLO: if (ackNow) state_next = ST_IDLE;
    endcase
  end

  // bus request for the next state, issued on the entering edge
  wire nextRead  = (state_next == ST_RDLO) || (state_next == ST_RDHI);
  wire nextWrite = (state_next == ST_WRLO) || (state_next == ST_WRHI)
                || (state_next == ST_PUSHHI) || (state_next == ST_PUSHLO);
  wire [19:0] addrNext = idleNow ? eaNow :
                         ((state_next == ST_RDHI) || (state_next == ST_WRHI))
                           ? opAddr_reg + WORD_STEP :                  // [RULE_15]
                         (state_next == ST_PUSHHI) ? spVal - WORD_STEP :
                         (state_next == ST_PUSHLO) ? spVal - PUSH_PAIR : opAddr_reg;
  wire [15:0] dataNext = (state_next == ST_WRLO)   ? wbLoNow :
                         (state_next == ST_WRHI)   ? wbHiNow :
                         (state_next == ST_PUSHHI) ? {12'h000, pcVal[19:16]} :  // [RULE_18]
                         (state_next == ST_PUSHLO) ? pcVal[15:0] : 16'h0000;

  // register file, one flop group per entry; port A wins a clash
  generate
    for (genvar g = 0; g < 16; g++)
    begin : gRegs
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          regFile[g] <= REG_RESET;
        else if (clkEn && wrEnA && (wrIdxA == 4'(g)))
          regFile[g] <= wrDataA;
        else if (clkEn && wrEnB && (wrIdxB == 4'(g)))
          regFile[g] <= wrDataB;
      end
    end
  endgenerate

  // sequencer and bus outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg    <= ST_IDLE;
      memReq_reg   <= 1'b0;
      memWe_reg    <= 1'b0;
      memAddr_reg  <= REG_RESET;
      memWdata_reg <= 16'h0000;
    end
    else if (clkEn)
    begin
      state_reg  <= state_next;
      memReq_reg <= nextRead || nextWrite;
      memWe_reg  <= nextWrite;
      // address and data only move on a state change, so a waiting
      // request holds still until the memory answers
      if (state_next != state_reg)
      begin
        memAddr_reg  <= addrNext;
        memWdata_reg <= dataNext;
      end
    end
  end

  // command latch; the target of a memory jump comes from the two reads
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      op_reg    <= EXT_SIGN_EXTEND;
      width_reg <= WD_BYTE;
      mode_reg  <= MD_REG;
      {dstIdx_reg, ptrIdx_reg, twoWords_reg} <= 9'h000;
      {opAddr_reg, srcVal_reg, tgt_reg} <= {REG_RESET, REG_RESET, REG_RESET};
    end
    else if (take)
    begin
      // enum fields are latched one by one so no packed vector meets an enum
      op_reg    <= cmdOp;
      width_reg <= cmdWidth;
      mode_reg  <= cmdMode;
      {dstIdx_reg, ptrIdx_reg} <= {cmdDstReg, ptrSel};
      twoWords_reg <= cmdJump || (cmdWidth == WD_ADDR);
      {opAddr_reg, srcVal_reg, tgt_reg} <= {eaNow, srcNow, tgtNow};
    end
    else if (clkEn && (state_reg == ST_RDHI) && ackNow)
      tgt_reg <= {memRdata[3:0], loData_reg};                          // [RULE_15]
  end

  // read data capture
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      {loData_reg, hiData_reg} <= 32'h00000000;
    else if (clkEn && ackNow && (state_reg == ST_RDLO))
      loData_reg <= memRdata;
    else if (clkEn && ackNow && (state_reg == ST_RDHI))
      hiData_reg <= memRdata;
  end

  // status pulses and the register peek port
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      {cmdDone_reg, cmdError_reg, peekData_reg} <= {1'b0, 1'b0, REG_RESET};
    else if (clkEn)
    begin
      cmdDone_reg  <= !idleNow && (state_next == ST_IDLE);
      cmdError_reg <= accept && cmdBad;                                // [RULE_11]
      peekData_reg <= regFile[peekIdx];
    end
  end

  assign cmdReady = idleNow;
  assign cmdDone  = cmdDone_reg;
  assign cmdError = cmdError_reg;
  assign memReq   = memReq_reg;
  assign memWe    = memWe_reg;
  assign memAddr  = memAddr_reg;
  assign memWdata = memWdata_reg;
  assign peekData = peekData_reg;

  // helper values for the checks below
  wire execSign = dstOperand[7];
  wire srcSign  = (width_reg == WD_BYTE) ? srcVal_reg[7] :
                  (width_reg == WD_WORD) ? srcVal_reg[15] : srcVal_reg[19];
  wire dstSign  = (width_reg == WD_BYTE) ? dstOperand[7] :
                  (width_reg == WD_WORD) ? dstOperand[15] : dstOperand[19];
  wire isOp;                     // register-mode execute step, status not the target
  assign isOp = execNow && !memMode && (dstIdx_reg != SR_IDX);

  sxt_reg_fill_a: assert property (isOp && op_reg == EXT_SIGN_EXTEND |=> // [RULE_01]
    regFile[$past(dstIdx_reg)][19:8] == {12{$past(execSign)}})
    else $error("sign extend did not fill bits 19:8");
  sxt_hi_zero_a: assert property (state_reg == ST_WRHI && op_reg == EXT_SIGN_EXTEND // [RULE_02]
    |-> memWdata_reg[15:4] == 12'h000) else $error("bits 31:20 not cleared");
  sxt_word_fill_a: assert property (state_reg == ST_WRLO && op_reg == EXT_SIGN_EXTEND // [RULE_03]
    && width_reg == WD_WORD |-> memWdata_reg[15:8] == {8{memWdata_reg[7]}})
    else $error("word sign extend wrong");
  sxt_flags_a: assert property (isOp && op_reg == EXT_SIGN_EXTEND |=> // [RULE_04]
    srVal[C_POS] == !srVal[Z_POS] && !srVal[V_POS]) else $error("extend flags wrong");
  mode_bits_a: assert property (1'b1 |=> // [RULE_05]
    (srVal & SR_MODE_MASK) == ($past(srVal) & SR_MODE_MASK)) else $error("mode bits changed");
  test_nowrite_a: assert property (execNow && op_reg == EXT_TEST_ZERO |=> // [RULE_06]
    state_reg == ST_IDLE && !memWe_reg) else $error("test wrote its operand");
  test_flags_a: assert property (execNow && op_reg == EXT_TEST_ZERO |=> // [RULE_07]
    srVal[C_POS] && !srVal[V_POS]) else $error("test C or V wrong");
  xor_over_a: assert property (isOp && op_reg == EXT_EXCLUSIVE_OR |=> // [RULE_09]
    srVal[V_POS] == ($past(srcSign) && $past(dstSign))) else $error("xor V wrong");
  word_clear_a: assert property (isOp && op_reg == EXT_EXCLUSIVE_OR && width_reg == WD_WORD // [RULE_10]
    |=> regFile[$past(dstIdx_reg)][19:16] == 4'h0) else $error("bits 19:16 not cleared");
  add_carry_a: assert property (isOp && op_reg == ADDR_ADD |=> // [RULE_13]
    srVal[C_POS] == (($past(srcVal_reg) + $past(dstOperand)) < $past(srcVal_reg)))
    else $error("add carry wrong");
  target_high_a: assert property (state_reg == ST_RDHI |-> // [RULE_15]
    memAddr_reg == opAddr_reg + WORD_STEP) else $error("high target word address wrong");
  ptr_step_a: assert property (execNow && jumpReg && mode_reg == MD_AINC // [RULE_16]
    && ptrIdx_reg != PC_IDX |=> regFile[$past(ptrIdx_reg)] == $past(ptrNow) + AINC_STEP)
    else $error("pointer not stepped by four");

  sequence pushHiDone_s;
    clkEn && state_reg == ST_PUSHHI && ackNow;
  endsequence
  sequence pushLoIssued_s;
    state_reg == ST_PUSHLO && memReq_reg && memWe_reg && memWdata_reg == pcVal[15:0];
  endsequence
  push_order_a: assert property (pushHiDone_s |=> pushLoIssued_s) // [RULE_18]
    else $error("low return word not pushed after high");
  push_high_a: assert property (state_reg == ST_PUSHHI |-> memAddr_reg == spVal - WORD_STEP // [RULE_18]
    && memWdata_reg == {12'h000, pcVal[19:16]}) else $error("high return word wrong");
  jump_flags_a: assert property (execNow && jumpReg |=> // [RULE_20]
    (srVal & SR_FLAG_MASK) == ($past(srVal) & SR_FLAG_MASK)) else $error("jump changed flags");

endmodule : ext_exec_unit
`default_nettype wire

/* shared/ext_exec_pkg.sv */
package ext_exec_pkg;

  // operations carried out by this execution unit
  typedef enum logic [2:0] {
    EXT_SIGN_EXTEND  = 3'h0,
    EXT_TEST_ZERO    = 3'h1,
    EXT_EXCLUSIVE_OR = 3'h2,
    ADDR_ADD         = 3'h3,
    ADDR_BRANCH      = 3'h4,
    ADDR_CALL        = 3'h5
  } op_t;

  // operand width: byte, word or 20-bit address-word
  typedef enum logic [1:0] {
    WD_BYTE = 2'h0,
    WD_WORD = 2'h1,
    WD_ADDR = 2'h2
  } width_t;

  // addressing mode of the operand (destination, or target for jumps)
  typedef enum logic [2:0] {
    MD_REG  = 3'h0,
    MD_IMM  = 3'h1,
    MD_ABS  = 3'h2,
    MD_SYM  = 3'h3,
    MD_IDX  = 3'h4,
    MD_IND  = 3'h5,
    MD_AINC = 3'h6
  } mode_t;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_RDLO   = 8'h02,
    ST_RDHI   = 8'h04,
    ST_EXEC   = 8'h08,
    ST_WRLO   = 8'h10,
    ST_WRHI   = 8'h20,
    ST_PUSHHI = 8'h40,
    ST_PUSHLO = 8'h80
  } state_t;

  // register file layout
  localparam logic [3:0]  PC_IDX     = 4'h0;
  localparam logic [3:0]  SP_IDX     = 4'h1;
  localparam logic [3:0]  SR_IDX     = 4'h2;
  localparam logic [19:0] REG_RESET  = 20'h00000;

  // status register bit positions
  localparam int C_POS                      = 0;
  localparam int Z_POS                      = 1;
  localparam int N_POS                      = 2;
  localparam int GLOBAL_IRQ_ENABLE_BIT_POS  = 3;
  localparam int CPU_OFF_BIT_POS            = 4;
  localparam int OSCILLATOR_OFF_BIT_POS     = 5;
  localparam int V_POS                      = 8;
  localparam logic [19:0] SR_MODE_MASK = (20'h1 << GLOBAL_IRQ_ENABLE_BIT_POS)
                                       | (20'h1 << CPU_OFF_BIT_POS)
                                       | (20'h1 << OSCILLATOR_OFF_BIT_POS);
  localparam logic [19:0] SR_FLAG_MASK = (20'h1 << C_POS) | (20'h1 << Z_POS)
                                       | (20'h1 << N_POS) | (20'h1 << V_POS);

  // operand width masks
  localparam logic [19:0] MASK_BYTE = 20'h000ff;
  localparam logic [19:0] MASK_WORD = 20'h0ffff;
  localparam logic [19:0] MASK_ADDR = 20'hfffff;

  // address steps
  localparam logic [19:0] WORD_STEP = 20'h00002;
  localparam logic [19:0] AINC_STEP = 20'h00004;
  localparam logic [19:0] PUSH_PAIR = 20'h00004;

endpackage : ext_exec_pkg

/* src/ext_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_alu (
  input  wire ext_exec_pkg::op_t    aluOp,
  input  wire ext_exec_pkg::width_t aluWidth,
  input  wire logic [19:0]          srcVal,
  input  wire logic [19:0]          dstVal,
  output logic [19:0]               result,
  output logic                      flagN,
  output logic                      flagZ,
  output logic                      flagC,
  output logic                      flagV
);
  import ext_exec_pkg::*;

  logic [19:0] widthMask;   // all-ones value of the operand width
  logic [19:0] srcM;        // source cut to width
  logic [19:0] dstM;        // destination cut to width
  logic [19:0] resM;        // result cut to width, basis of N and Z
  logic [19:0] sextVal;     // low byte sign spread over 19:8
  logic [20:0] testSum;     // dst + all-ones + 1, flags only
  logic [20:0] addSum;      // full 20-bit sum with carry
  logic        srcSign;
  logic        dstSign;

  // sign bit of a value at the current width [RULE_21]
  function automatic logic signOf(input logic [19:0] v, input width_t w);
    signOf = (w == WD_BYTE) ? v[7] : (w == WD_WORD) ? v[15] : v[19];
  endfunction : signOf

  assign widthMask = (aluWidth == WD_BYTE) ? MASK_BYTE :
                     (aluWidth == WD_WORD) ? MASK_WORD : MASK_ADDR;
  assign srcM      = srcVal & widthMask;
  assign dstM      = dstVal & widthMask;
  assign sextVal   = {{12{dstVal[7]}}, dstVal[7:0]};                      // [RULE_01]
  assign testSum   = {1'b0, dstM} + {1'b0, widthMask} + 21'h000001;       // [RULE_06]
  assign addSum    = {1'b0, srcVal} + {1'b0, dstVal};                     // [RULE_12]
  assign srcSign   = signOf(srcM, aluWidth);
  assign dstSign   = signOf(dstM, aluWidth);
  assign resM      = result & widthMask;

  // result select; exclusive-OR is cut to width, which clears the upper
  // register bits of word and byte destinations [RULE_10] [RULE_22]
  always_comb
  begin
    unique case (aluOp)
      EXT_SIGN_EXTEND:  result = sextVal;
      EXT_TEST_ZERO:    result = testSum[19:0] & widthMask;
      EXT_EXCLUSIVE_OR: result = srcM ^ dstM;                            // [RULE_08]
      ADDR_ADD:         result = addSum[19:0];
      default:          result = dstVal;
    endcase
  end

  // flags, meaningful only for the four data operations
  always_comb
  begin
    flagN = signOf(resM, aluWidth);                                      // [RULE_21]
    flagZ = (resM == 20'h00000);
    unique case (aluOp)
      EXT_SIGN_EXTEND:  {flagC, flagV} = {~flagZ, 1'b0};                 // [RULE_04]
      EXT_TEST_ZERO:    {flagC, flagV} = {1'b1, 1'b0};                   // [RULE_07]
      EXT_EXCLUSIVE_OR: {flagC, flagV} = {~flagZ, srcSign & dstSign};    // [RULE_09]
      ADDR_ADD:         {flagC, flagV} = {addSum[20],                    // [RULE_13]
                         (srcVal[19] == dstVal[19]) && (addSum[19] != srcVal[19])};
      default:          {flagC, flagV} = 2'b00;
    endcase
  end

endmodule : ext_alu
`default_nettype wire

/* verification/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// word memory on the cpu buses, acks after a random number of idle cycles
module mem_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [19:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata,
  output logic             memAck
);
  logic [15:0] m [0:255];      // small window of the address space
  int          s = 32'h9c09351a; // delay seed
  // ack lasts one cycle; read data is inverted once released so a stale word never passes
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      memAck   <= 1'b0;
      memRdata <= 16'h5a5a;
    end
    else if (memAck)
    begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      if (memWe)
        m[memAddr[8:1]] <= memWdata;
    end
    else if (memReq && (($random(s) & 1) != 0))
    begin
      memAck   <= 1'b1;
      memRdata <= m[memAddr[8:1]];
    end
  end
endmodule : mem_model
`default_nettype wire

/* verification/cpu_ext_insn_exec_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_ext_insn_exec_test;
  import ext_exec_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, cmdValid = 1'b0, pkReq = 1'b0, pk1 = 1'b0;
  logic cmdReady, cmdDone, cmdError, memReq, memWe, memAck;
  op_t cmdOp = ADDR_ADD;
  width_t cmdWidth = WD_ADDR;
  mode_t cmdMode = MD_REG;
  logic [3:0] cmdSrcReg = 4'h0, cmdDstReg = 4'h0, peekIdx = 4'h0;
  logic [19:0] cmdImm = 20'h0, memAddr, peekData, r, x;
  logic [15:0] memWdata, memRdata;
  logic [19:0] q[$]; // expected results, oldest first
  int errors = 0, n_tests = 0, seed = 32'h9c09351a;
  always #12.5 sys_clk = ~sys_clk;
  ext_exec_unit uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdWidth(cmdWidth), .cmdMode(cmdMode), .cmdSrcImm(1'b1),
    .cmdSrcReg(cmdSrcReg), .cmdDstReg(cmdDstReg), .cmdImm(cmdImm), .cmdAbs(cmdImm),
    .cmdIndex(16'h0), .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdError(cmdError),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .peekIdx(peekIdx), .peekData(peekData));
  mem_model mm (.sys_clk(sys_clk), .sys_rst(sys_rst), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
  // status word from flags: c0 z1 n2 v8, mode bits stay clear
  function automatic logic [19:0] sr(input logic n, z, c, v);
    return {11'h0, v, 5'h0, n, z, c};
  endfunction : sr
  task check(input string nm, input logic [19:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task close_out;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // one command, held until taken, then wait for done or error
  task cmd(input op_t o, width_t w, mode_t m, logic [3:0] s, d, logic [19:0] v, logic e);
    int k;
    q.push_back({19'h0, e});
    cmdOp <= o;
    cmdWidth <= w;
    cmdMode <= m;
    cmdSrcReg <= s;
    cmdDstReg <= d;
    cmdImm <= v;
    cmdValid <= 1'b1;
    do @(posedge sys_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    for (k = 0; k < 200 && !(cmdDone | cmdError); k++) @(posedge sys_clk);
    if (k == 200)
      errors++;
  endtask : cmd
  // register peek: data shows one cycle after the index
  task pk(input logic [3:0] i, logic [19:0] v);
    q.push_back(v);
    peekIdx <= i;
    pkReq <= 1'b1;
    @(posedge sys_clk);
    pkReq <= 1'b0;
    @(posedge sys_clk);
  endtask : pk
  // monitor: every peek or completion takes the oldest note
  always @(posedge sys_clk)
  begin
    if (pk1 || cmdDone || cmdError)
      check(pk1 ? "peek" : "error", pk1 ? peekData : {19'h0, cmdError}, q.pop_front());
    pk1 <= pkReq;
  end
  initial
  begin
    #(25 * 20000);
    errors++;
    close_out;
  end
  initial
  begin
    mm.m[8'h20] = 16'h5678;
    mm.m[8'h21] = 16'h0009;
    mm.m[8'h30] = 16'h0080;
    mm.m[8'h31] = 16'habcd;
    r = $random(seed);
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cmd(ADDR_ADD, WD_ADDR, MD_IMM, 4'h0, 4'h4, 20'h00080, 1'b0);
    pk(4'h4, 20'h00080);
    pk(4'h2, sr(0, 0, 0, 0));
    cmd(EXT_SIGN_EXTEND, WD_WORD, MD_REG, 4'h0, 4'h4, 20'h0, 1'b0);
    pk(4'h4, 20'hfff80);
    pk(4'h2, sr(1, 0, 1, 0));
    cmd(EXT_TEST_ZERO, WD_ADDR, MD_REG, 4'h0, 4'h4, 20'h0, 1'b0);
    pk(4'h4, 20'hfff80);
    pk(4'h2, sr(1, 0, 1, 0));
    cmd(EXT_EXCLUSIVE_OR, WD_WORD, MD_REG, 4'h0, 4'h4, r, 1'b0);
    x = (r ^ 20'hfff80) & 20'h0ffff;
    pk(4'h4, x);
    pk(4'h2, sr(x[15], x == 0, x != 0, r[15]));
    cmd(EXT_EXCLUSIVE_OR, WD_BYTE, MD_REG, 4'h0, 4'h4, 20'hfff01, 1'b0);
    pk(4'h4, (x ^ 20'h00001) & 20'h000ff);
    cmd(ADDR_ADD, WD_ADDR, MD_IMM, 4'h0, 4'h5, 20'h7ffff, 1'b0);
    cmd(ADDR_ADD, WD_ADDR, MD_IMM, 4'h0, 4'h5, 20'h00001, 1'b0);
    pk(4'h2, sr(1, 0, 0, 1));
    cmd(ADDR_ADD, WD_ADDR, MD_IMM, 4'h0, 4'h5, 20'h80000, 1'b0);
    pk(4'h5, 20'h0);
    pk(4'h2, sr(0, 1, 1, 1));
    cmd(ADDR_BRANCH, WD_ADDR, MD_IMM, 4'h0, 4'h0, 20'h12345, 1'b0);
    pk(4'h0, 20'h12345);
    pk(4'h2, sr(0, 1, 1, 1));
    cmd(ADDR_ADD, WD_ADDR, MD_IMM, 4'h0, 4'h1, 20'h00100, 1'b0);
    cmd(ADDR_CALL, WD_ADDR, MD_REG, 4'h4, 4'h0, 20'h0, 1'b0);
    pk(4'h0, (x ^ 20'h00001) & 20'h000ff);
    pk(4'h1, 20'h000fc);
    check("stack hi", {4'h0, mm.m[8'h7f]}, 20'h00001);
    check("stack lo", {4'h0, mm.m[8'h7e]}, 20'h02345);
    cmd(ADDR_BRANCH, WD_ADDR, MD_ABS, 4'h0, 4'h0, 20'h00040, 1'b0);
    pk(4'h0, 20'h95678);
    cmd(EXT_SIGN_EXTEND, WD_ADDR, MD_ABS, 4'h0, 4'h0, 20'h00060, 1'b0);
    check("ext lo", {4'h0, mm.m[8'h30]}, 20'h0ff80);
    check("ext hi", {4'h0, mm.m[8'h31]}, 20'h0000f);
    cmd(ADDR_ADD, WD_ADDR, MD_ABS, 4'h0, 4'h4, 20'h0, 1'b1);
    pk(4'h2, sr(1, 0, 1, 0));
    // the last peek is compared on the edge pk returns; let it drain
    repeat (3) @(posedge sys_clk);
    if (q.size() != 0)
      errors++;
    close_out;
  end
endmodule : cpu_ext_insn_exec_test
`default_nettype wire
